// file: design/pll_regs_map.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 100 MHz ref_clk, byte-wide register space of the synthesizer
// Notes:   host register offsets are for the bus controller's own port
`ifndef PLL_REGS_MAP_SVH
`define PLL_REGS_MAP_SVH
`define RA_INPUT_CONTROL  8'h00
`define RA_LOOP_CONTROL   8'h01
`define RA_FB_DIV_LOW     8'h02
`define RA_FB_DIV_HIGH    8'h03
`define RA_RESERVED_FOUR  8'h04
`define RA_CONDITIONING   8'h05
`define RA_OUTPUT_ENABLES 8'h06
`define RA_RESERVED_SEVEN 8'h07
`define RA_SOFT_RESET     8'h08
`define RA_VERSION        8'h10
`define RA_REVISION       8'h11
`define RA_LOCK_STATUS    8'h12
`define IC_GATE_BIT       0
`define IC_COAST_BIT      1
`define IC_HSYNC_BIT      2
`define IC_FBPOL_BIT      3
`define IC_FBSEL_BIT      4
`define IC_LOCKEN_BIT     6
`define IC_WMASK          8'h5F
`define IC_RESET          8'h41
`define LOOP_WMASK        8'h37
`define COND_RESET        1'b1
`define OE_BIT            1
`define LOCK_BIT          1
`define COMMIT_KEY        8'h5A
`define FB_DIV_OFFSET     13'h0008
`define DEV_ADDR_HI6      6'h13
`define CLK_NS            10
`define SCL_T100_NS       10000
`define SCL_T400_NS       2500
`define SCL_Q100 ((`SCL_T100_NS + 4 * `CLK_NS - 1) / (4 * `CLK_NS))
`define SCL_Q400 ((`SCL_T400_NS + 4 * `CLK_NS - 1) / (4 * `CLK_NS))
`define HR_TARGET         3'h0
`define HR_WDATA          3'h1
`define HR_CTRL           3'h2
`define HR_STATUS         3'h3
`define HR_RDATA          3'h4
`endif

// file: design/pll_regs_pkg.sv
// Purpose: state types for both ends of the serial register link
// Assumes: nothing beyond the map header
// Notes:   one packed struct per module holds all of its state
package pll_regs_pkg;
  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_WORD, D_WDATA, D_RDATA} dev_state_e;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BITS, H_STOP} host_state_e;
  typedef struct packed {
    dev_state_e st;
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic [1:0] asel_q;
    logic [1:0] lock_q;
    logic [1:0] vs_q;
    logic [3:0] cnt;
    logic       ack;
    logic       rw;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic       sda_oe;
    logic [7:0] input_control;
    logic [7:0] loop_sh;
    logic [7:0] loop_act;
    logic [7:0] fdl_sh;
    logic [7:0] fdl_act;
    logic [3:0] fdh_sh;
    logic [3:0] fdh_act;
    logic       cond_sh;
    logic       cond_act;
    logic       oe_bit;
    logic [7:0] rsv7;
    logic       pll_reset;
    logic       pump_en;
    logic       lock_out;
    logic [7:0] pump_ua;
    logic [4:0] vco_ratio;
    logic [12:0] fb_ratio;
  } dev_s;
  typedef struct packed {
    host_state_e st;
    logic [1:0] ph;
    logic [7:0] cnt;
    logic [3:0] bitn;
    logic [1:0] bi;
    logic [7:0] sh;
    logic       rd_op;
    logic       fast;
    logic       nack;
    logic [8:0] target;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [15:0] port_q;
    logic [1:0] sda_q;
    logic       scl_oe;
    logic       sda_oe;
  } host_s;
endpackage

// file: design/i2c_link_if.sv
// Purpose: two-wire open-drain link between controller and synthesizer
// Assumes: pull-ups on both wires; enables high while a party pulls low
// Notes:   wire levels resolved here from the enables
`timescale 1ns/1ps
interface i2c_link_if;
  logic scl_oe_host;
  logic sda_oe_host;
  logic sda_oe_dev;
  logic scl;
  logic sda;
  assign scl = ~scl_oe_host;
  assign sda = ~(sda_oe_host | sda_oe_dev);
  modport dev (input scl, input sda, output sda_oe_dev);
  modport host (input scl, input sda, output scl_oe_host, output sda_oe_host);
endinterface

// file: design/pll_reg_device.sv
// Purpose: synthesizer control/status register bank behind a serial slave
// Assumes: link pins and status inputs are asynchronous to ref_clk
// Notes:   no clock stretching; analog loop lives outside this block
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "pll_regs_map.svh"
module pll_reg_device #(
  parameter logic [6:0] METAL_REV   = 7'h00,  // Arbitrary value
  parameter logic [7:0] VERSION_ID  = 8'h00,  // Arbitrary value
  parameter logic [7:0] REVISION_ID = 8'h3C   // Arbitrary value
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  i2c_link_if.dev          link,
  input  wire logic        bus_address_select_pin,
  input  wire logic        vsync_in,
  input  wire logic        lock_in,
  output logic             pump_gate_select,
  output logic             coast_polarity,
  output logic             hsync_falling_edge,
  output logic             fb_falling_edge,
  output logic             external_feedback_sel,
  output logic             lock_pin_enable,
  output logic             lock_out,
  output logic             charge_pump_enable,
  output logic [2:0]       pump_current_code,
  output logic [7:0]       pump_current_ua,
  output logic [1:0]       vco_post_divide_code,
  output logic [4:0]       vco_divide_ratio,
  output logic [12:0]      feedback_ratio,
  output logic             schmitt_bypass,
  output logic             video_out_enable,
  output logic             pll_reset_pulse
);
  pll_regs_pkg::dev_s r;
  pll_regs_pkg::dev_s n;

  always_comb begin
    logic       rise;
    logic       fall;
    logic       start_c;
    logic       stop_c;
    logic       sda_in;
    logic [7:0] rb;
    logic [7:0] next_ptr;
    rise     = r.scl_q[1] & ~r.scl_q[2];
    fall     = ~r.scl_q[1] & r.scl_q[2];
    sda_in   = r.sda_q[1];
    rb       = 8'h00;
    start_c  = r.scl_q[1] & r.scl_q[2] & ~r.sda_q[1] & r.sda_q[2];
    stop_c   = r.scl_q[1] & r.scl_q[2] & r.sda_q[1] & ~r.sda_q[2];
    next_ptr = {r.ptr[7:4], r.ptr[3:0] + 4'h1};
    n = r;
    n.scl_q     = {r.scl_q[1:0], link.scl};
    n.sda_q     = {r.sda_q[1:0], link.sda};
    n.asel_q    = {r.asel_q[0], bus_address_select_pin};
    n.lock_q    = {r.lock_q[0], lock_in};
    n.vs_q      = {r.vs_q[0], vsync_in};
    n.pll_reset = 1'b0;
    unique case (r.ptr)
      `RA_INPUT_CONTROL:  rb = r.input_control;
      `RA_LOOP_CONTROL:   rb = r.loop_sh;
      `RA_FB_DIV_LOW:     rb = r.fdl_sh;
      `RA_FB_DIV_HIGH:    rb = {4'h0, r.fdh_sh};
      `RA_CONDITIONING:   rb = {METAL_REV, r.cond_sh};
      `RA_OUTPUT_ENABLES: rb = {6'h00, r.oe_bit, 1'b0};
      `RA_RESERVED_SEVEN: rb = r.rsv7;
      `RA_VERSION:        rb = VERSION_ID;
      `RA_REVISION:       rb = REVISION_ID;
      `RA_LOCK_STATUS:    rb = {6'h00, r.lock_q[1], 1'b0};
      default:            rb = 8'h00;
    endcase
    if (start_c) begin
      n.st     = pll_regs_pkg::D_ADDR;
      n.cnt    = 4'h0;
      n.ack    = 1'b0;
      n.sda_oe = 1'b0;
    end else if (stop_c) begin
      n.st     = pll_regs_pkg::D_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      unique case (r.st)
        pll_regs_pkg::D_IDLE: n.sda_oe = 1'b0;
        pll_regs_pkg::D_RDATA: begin
          if (rise) begin
            n.cnt = r.cnt + 4'h1;
            // Master not acknowledging ends the read
            if (r.cnt == 4'h8 && sda_in)
              n.st = pll_regs_pkg::D_IDLE;
          end else if (fall) begin
            if (r.cnt < 4'h8) begin
              n.sda_oe = ~r.sh[3'(4'h7 - r.cnt)];
            end else if (r.cnt == 4'h8) begin
              n.sda_oe = 1'b0;
            end else begin
              n.sh     = rb;
              n.ptr    = next_ptr;
              n.cnt    = 4'h0;
              n.sda_oe = ~rb[7];
            end
          end
        end
        default: begin
          if (rise && r.cnt < 4'h8) begin
            n.sh  = {r.sh[6:0], sda_in};
            n.cnt = r.cnt + 4'h1;
          end else if (fall && r.cnt == 4'h8 && !r.ack) begin
            n.ack    = 1'b1;
            n.sda_oe = 1'b1;
            unique case (r.st)
              pll_regs_pkg::D_ADDR: begin
                n.rw = r.sh[0];
                if (r.sh[7:1] != {`DEV_ADDR_HI6, r.asel_q[1]}) begin
                  n.st     = pll_regs_pkg::D_IDLE;
                  n.sda_oe = 1'b0;
                end
              end
              pll_regs_pkg::D_WORD: n.ptr = r.sh;
              default: begin
                n.ptr = next_ptr;
                unique case (r.ptr)
                  `RA_INPUT_CONTROL:  n.input_control = r.sh & `IC_WMASK;
                  `RA_LOOP_CONTROL:   n.loop_sh = r.sh & `LOOP_WMASK;
                  `RA_FB_DIV_LOW:     n.fdl_sh  = r.sh;
                  `RA_FB_DIV_HIGH:    n.fdh_sh  = r.sh[3:0];
                  `RA_CONDITIONING:   n.cond_sh = r.sh[0];
                  `RA_OUTPUT_ENABLES: n.oe_bit  = r.sh[`OE_BIT];
                  `RA_RESERVED_SEVEN: n.rsv7    = r.sh;
                  `RA_SOFT_RESET: begin
                    if (r.sh == `COMMIT_KEY) begin
                      n.loop_act  = r.loop_sh;
                      n.fdl_act   = r.fdl_sh;
                      n.fdh_act   = r.fdh_sh;
                      n.cond_act  = r.cond_sh;
                      n.pll_reset = 1'b1;
                    end
                  end
                  default: ;
                endcase
              end
            endcase
          end else if (fall && r.ack) begin
            n.ack    = 1'b0;
            n.cnt    = 4'h0;
            n.sda_oe = 1'b0;
            unique case (r.st)
              pll_regs_pkg::D_ADDR: begin
                if (r.rw) begin
                  n.st     = pll_regs_pkg::D_RDATA;
                  n.sh     = rb;
                  n.ptr    = next_ptr;
                  n.sda_oe = ~rb[7];
                end else begin
                  n.st = pll_regs_pkg::D_WORD;
                end
              end
              default: n.st = pll_regs_pkg::D_WDATA;
            endcase
          end
        end
      endcase
    end
    // Coast gating of the pump from the synchronised vsync
    n.pump_en   = r.input_control[`IC_GATE_BIT]
                | (r.vs_q[1] ^ r.input_control[`IC_COAST_BIT]);
    n.lock_out  = r.lock_q[1] & r.input_control[`IC_LOCKEN_BIT];
    n.pump_ua   = 8'h01 << r.loop_act[2:0];
    n.vco_ratio = 5'h02 << r.loop_act[5:4];
    n.fb_ratio  = {1'b0, r.fdh_act, r.fdl_act} + `FB_DIV_OFFSET;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r               <= '0;
      r.scl_q         <= 3'h7;
      r.sda_q         <= 3'h7;
      r.input_control <= `IC_RESET;
      r.cond_sh       <= `COND_RESET;
      r.cond_act      <= `COND_RESET;
      r.pump_en       <= 1'b1;
      r.pump_ua       <= 8'h01;
      r.vco_ratio     <= 5'h02;
      r.fb_ratio      <= `FB_DIV_OFFSET;
    end else if (clk_en) begin
      r <= n;
    end
  end

  assign link.sda_oe_dev      = r.sda_oe;
  assign pump_gate_select      = r.input_control[`IC_GATE_BIT];
  assign coast_polarity        = r.input_control[`IC_COAST_BIT];
  assign hsync_falling_edge    = r.input_control[`IC_HSYNC_BIT];
  assign fb_falling_edge       = r.input_control[`IC_FBPOL_BIT];
  assign external_feedback_sel = r.input_control[`IC_FBSEL_BIT];
  assign lock_pin_enable       = r.input_control[`IC_LOCKEN_BIT];
  assign lock_out              = r.lock_out;
  assign charge_pump_enable    = r.pump_en;
  assign pump_current_code     = r.loop_act[2:0];
  assign pump_current_ua       = r.pump_ua;
  assign vco_post_divide_code  = r.loop_act[5:4];
  assign vco_divide_ratio      = r.vco_ratio;
  assign feedback_ratio        = r.fb_ratio;
  assign schmitt_bypass        = r.cond_act;
  assign video_out_enable      = r.oe_bit;
  assign pll_reset_pulse       = r.pll_reset;
endmodule

// file: design/i2c_reg_master.sv
// Purpose: serial bus master that reads and writes single device registers
// Assumes: one target on the link, no clock stretching by the target
// Notes:   SCL made from ref_clk by a quarter-period divider
`timescale 1ns/1ps
`include "pll_regs_map.svh"
module i2c_reg_master (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  i2c_link_if.host         link,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  output logic             busy
);
  localparam logic [7:0] Q100 = 8'(`SCL_Q100 - 1);
  localparam logic [7:0] Q400 = 8'(`SCL_Q400 - 1);

  pll_regs_pkg::host_s r;
  pll_regs_pkg::host_s n;

  always_comb begin
    logic       tick;
    logic       go;
    logic [7:0] nb;
    tick = (r.cnt == 8'h00);
    go   = 1'b0;
    nb   = 8'h00;
    n = r;
    n.sda_q = {r.sda_q[0], link.sda};
    unique case (reg_addr)
      `HR_TARGET: n.port_q = {7'h00, r.target};
      `HR_WDATA:  n.port_q = {8'h00, r.wdata};
      `HR_CTRL:   n.port_q = {13'h0000, r.fast, 2'b00};
      `HR_STATUS: n.port_q = {13'h0000, r.fast, r.nack, r.st != pll_regs_pkg::H_IDLE};
      `HR_RDATA:  n.port_q = {8'h00, r.rdata};
      default:    n.port_q = 16'h0000;
    endcase
    if (!reg_rd)
      n.port_q = r.port_q;
    if (reg_wr && r.st == pll_regs_pkg::H_IDLE) begin
      unique case (reg_addr)
        `HR_TARGET: n.target = reg_wdata[8:0];
        `HR_WDATA:  n.wdata  = reg_wdata[7:0];
        `HR_CTRL: begin
          n.fast  = reg_wdata[2];
          n.rd_op = reg_wdata[1];
          go      = reg_wdata[0] | reg_wdata[1];
        end
        default: ;
      endcase
    end
    // Byte for the next slot of the transfer
    unique case (r.bi)
      2'h0:    nb = {`DEV_ADDR_HI6, r.target[8], 1'b0};
      2'h1:    nb = r.target[7:0];
      2'h2:    nb = r.rd_op ? {`DEV_ADDR_HI6, r.target[8], 1'b1} : r.wdata;
      default: nb = 8'hFF;
    endcase
    if (go) begin
      n.st   = pll_regs_pkg::H_START;
      n.ph   = 2'h0;
      n.bi   = 2'h0;
      n.nack = 1'b0;
      n.cnt  = reg_wdata[2] ? Q400 : Q100;
    end else if (r.st != pll_regs_pkg::H_IDLE) begin
      n.cnt = tick ? (r.fast ? Q400 : Q100) : r.cnt - 8'h01;
      if (tick) begin
        n.ph = r.ph + 2'h1;
        unique case (r.st)
          pll_regs_pkg::H_START: begin
            if (r.ph == 2'h3) begin
              n.st   = pll_regs_pkg::H_BITS;
              n.bitn = 4'h0;
              n.sh   = nb;
            end
          end
          pll_regs_pkg::H_BITS: begin
            if (r.ph == 2'h2) begin
              if (r.bitn < 4'h8 && r.bi == 2'h3)
                n.rdata = {r.rdata[6:0], r.sda_q[1]};
              else if (r.bitn == 4'h8 && r.bi != 2'h3)
                n.nack = r.sda_q[1];
            end else if (r.ph == 2'h3) begin
              n.sh   = {r.sh[6:0], 1'b0};
              n.bitn = r.bitn + 4'h1;
              if (r.bitn == 4'h8) begin
                n.bitn = 4'h0;
                n.bi   = r.bi + 2'h1;
                if (r.nack || r.bi == 2'h3 || (!r.rd_op && r.bi == 2'h2))
                  n.st = pll_regs_pkg::H_STOP;
                else if (r.rd_op && r.bi == 2'h1)
                  n.st = pll_regs_pkg::H_START;
                else
                  n.sh = (r.bi == 2'h0) ? r.target[7:0] : r.wdata;
              end
            end
          end
          pll_regs_pkg::H_STOP: begin
            if (r.ph == 2'h3)
              n.st = pll_regs_pkg::H_IDLE;
          end
          default: ;
        endcase
      end
    end
    // Pin drive from the next state keeps both wires glitch-free
    unique case (n.st)
      pll_regs_pkg::H_IDLE: begin
        n.scl_oe = 1'b0;
        n.sda_oe = 1'b0;
      end
      pll_regs_pkg::H_START: begin
        n.scl_oe = n.ph[0] == n.ph[1];
        n.sda_oe = n.ph[1];
      end
      pll_regs_pkg::H_BITS: begin
        n.scl_oe = n.ph[0] == n.ph[1];
        n.sda_oe = (n.bitn < 4'h8 && n.bi != 2'h3) ? ~n.sh[7] : 1'b0;
      end
      pll_regs_pkg::H_STOP: begin
        n.scl_oe = n.ph == 2'h0;
        n.sda_oe = n.ph < 2'h2;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r       <= '0;
      r.sda_q <= 2'h3;
    end else if (clk_en) begin
      r <= n;
    end
  end

  assign link.scl_oe_host = r.scl_oe;
  assign link.sda_oe_host = r.sda_oe;
  assign reg_rdata        = r.port_q;
  assign busy             = r.st != pll_regs_pkg::H_IDLE;
endmodule

// file: verif/pll_link_assertions.sv
// Purpose: properties of the serial link and the committed PLL settings
// Assumes: one ref_clk domain, rst synchronous and active high
// Notes:   watches link wires and device outputs only, never bench drives
`timescale 1ns/1ps
module pll_link_assertions (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        scl_oe_host,
  input wire logic        sda_oe_dev,
  input wire logic        scl,
  input wire logic        pump_gate_select,
  input wire logic        charge_pump_enable,
  input wire logic        lock_pin_enable,
  input wire logic        lock_out,
  input wire logic [2:0]  pump_current_code,
  input wire logic [7:0]  pump_current_ua,
  input wire logic [1:0]  vco_post_divide_code,
  input wire logic [4:0]  vco_divide_ratio,
  input wire logic [12:0] feedback_ratio,
  input wire logic        schmitt_bypass,
  input wire logic        video_out_enable,
  input wire logic        pll_reset_pulse
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_one_pulse;
    pll_reset_pulse ##1 !pll_reset_pulse;
  endsequence
  sequence s_scl_held;
    scl [*8];
  endsequence

  reset_values_a: assert property (
    $fell(rst) |-> pump_gate_select && lock_pin_enable && schmitt_bypass
      && !video_out_enable && !sda_oe_dev && !scl_oe_host && pump_current_ua == 8'h01)
    else $error("settings wrong after reset");
  pump_always_on_a: assert property (
    pump_gate_select [*2] |-> charge_pump_enable)
    else $error("pump gated while forced on");
  lock_pin_off_a: assert property (
    !lock_pin_enable [*2] |-> !lock_out)
    else $error("lock output active while disabled");
  pump_current_a: assert property (
    $stable(pump_current_code) |-> pump_current_ua == (8'h01 << pump_current_code))
    else $error("pump current does not match code");
  post_divide_a: assert property (
    $stable(vco_post_divide_code) |-> vco_divide_ratio == (5'h02 << vco_post_divide_code))
    else $error("post divide ratio does not match code");
  fb_range_a: assert property (
    feedback_ratio >= 13'h0008 && feedback_ratio <= 13'h1007)
    else $error("feedback ratio out of range");
  commit_pulse_a: assert property (
    pll_reset_pulse |-> s_one_pulse)
    else $error("commit pulse longer than one cycle");
  staged_only_a: assert property (
    $changed({feedback_ratio, pump_current_code, vco_post_divide_code, schmitt_bypass})
      |-> pll_reset_pulse || $past(pll_reset_pulse) || $past(pll_reset_pulse, 2))
    else $error("staged setting changed without commit");
  ack_timing_a: assert property (
    $changed(sda_oe_dev) |-> !scl)
    else $error("device moved data line while clock high");
  scl_high_a: assert property (
    $rose(scl) |=> s_scl_held)
    else $error("serial clock high phase too short");
endmodule

// file: verif/video_pll_control_regs_tb_top.sv
// Purpose: self-checking bench for the serial master and PLL register bank
// Assumes: both ends joined by the link interface, fast link unless noted
// Notes:   one slow transfer only, since each costs about 29k cycles
`timescale 1ns/1ps
`include "pll_regs_map.svh"
module video_pll_control_regs_tb_top;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        asel = 1'b1;
  logic        vsync_in = 1'b0;
  logic        lock_in = 1'b1;
  logic [2:0]  reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        busy;
  logic        pump_gate_select, coast_polarity, hsync_falling_edge, fb_falling_edge;
  logic        external_feedback_sel, lock_pin_enable, lock_out, charge_pump_enable;
  logic        schmitt_bypass, video_out_enable, pll_reset_pulse;
  logic [2:0]  pump_current_code;
  logic [7:0]  pump_current_ua;
  logic [1:0]  vco_post_divide_code;
  logic [4:0]  vco_divide_ratio;
  logic [12:0] feedback_ratio;
  logic [7:0]  ctl_vec;
  logic [7:0]  rd;
  int          num_errors = 0;
  int          checks_done = 0;
  int          pulses = 0;

  assign ctl_vec = {pump_gate_select, coast_polarity, hsync_falling_edge, fb_falling_edge,
                    external_feedback_sel, lock_pin_enable, schmitt_bypass, video_out_enable};

  i2c_link_if link();
  pll_reg_device u_pll_reg_device (.ref_clk, .rst, .clk_en(1'b1), .link(link.dev),
    .bus_address_select_pin(asel), .vsync_in, .lock_in, .pump_gate_select, .coast_polarity,
    .hsync_falling_edge, .fb_falling_edge, .external_feedback_sel, .lock_pin_enable,
    .lock_out, .charge_pump_enable, .pump_current_code, .pump_current_ua,
    .vco_post_divide_code, .vco_divide_ratio, .feedback_ratio, .schmitt_bypass,
    .video_out_enable, .pll_reset_pulse);
  i2c_reg_master u_i2c_reg_master (.ref_clk, .rst, .clk_en(1'b1), .link(link.host),
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .busy);
  pll_link_assertions u_pll_link_assertions (.ref_clk, .rst,
    .scl_oe_host(link.scl_oe_host), .sda_oe_dev(link.sda_oe_dev), .scl(link.scl),
    .pump_gate_select, .charge_pump_enable, .lock_pin_enable, .lock_out,
    .pump_current_code, .pump_current_ua, .vco_post_divide_code, .vco_divide_ratio,
    .feedback_ratio, .schmitt_bypass, .video_out_enable, .pll_reset_pulse);

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (pll_reset_pulse === 1'b1) pulses++;

  task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic bus_wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    // Data stand in the cycle after the strobe; taken at its closing edge
    @(posedge ref_clk);
    d = reg_rdata;
  endtask

  // Polls status over the register port, as software would
  task automatic link_op(input logic [8:0] tgt, input logic [7:0] wd, input logic [2:0] ctl,
                         input logic nack, output logic [7:0] r);
    logic [15:0] st;
    bus_wr(`HR_TARGET, 16'(tgt));
    bus_wr(`HR_WDATA, 16'(wd));
    bus_wr(`HR_CTRL, 16'(ctl));
    repeat (3) @(posedge ref_clk);
    cmp("busy pin", 16'h0001, 16'(busy));
    for (int n = 0; n < 30000; n++) begin
      bus_rd(`HR_STATUS, st);
      if (st[0] === 1'b0) break;
    end
    cmp("busy", 16'h0000, 16'(st[0]));
    cmp("busy pin", 16'h0000, 16'(busy));
    cmp("nack", 16'(nack), 16'(st[1]));
    bus_rd(`HR_RDATA, st);
    r = st[7:0];
  endtask

  task automatic dev_wr(input logic [7:0] a, input logic [7:0] d, input logic fast);
    link_op({asel, a}, d, {fast, 2'b01}, 1'b0, rd);
  endtask

  task automatic t_reset;
    repeat (5) @(posedge ref_clk);
    cmp("control outputs", 16'h0086, 16'(ctl_vec));
    cmp("lock out", 16'h0001, 16'(lock_out));
    cmp("pump enable", 16'h0001, 16'(charge_pump_enable));
    cmp("pump ua", 16'h0001, 16'(pump_current_ua));
    cmp("vco ratio", 16'h0002, 16'(vco_divide_ratio));
    cmp("fb ratio", 16'h0008, 16'(feedback_ratio));
  endtask

  task automatic t_input;
    dev_wr(`RA_INPUT_CONTROL, 8'h1E, 1'b1);
    cmp("control outputs", 16'h007A, 16'(ctl_vec));
    cmp("lock out", 16'h0000, 16'(lock_out));
    vsync_in <= 1'b1;
    repeat (6) @(posedge ref_clk);
    cmp("coast high", 16'h0000, 16'(charge_pump_enable));
    vsync_in <= 1'b0;
    repeat (6) @(posedge ref_clk);
    cmp("coast low", 16'h0001, 16'(charge_pump_enable));
  endtask

  task automatic t_staged;
    dev_wr(`RA_LOOP_CONTROL, 8'h33, 1'b1);
    dev_wr(`RA_FB_DIV_HIGH, 8'h0F, 1'b1);
    dev_wr(`RA_CONDITIONING, 8'h00, 1'b1);
    dev_wr(`RA_RESERVED_SEVEN, 8'h00, 1'b1);
    cmp("staged schmitt", 16'h0001, 16'(schmitt_bypass));
    cmp("staged ua", 16'h0001, 16'(pump_current_ua));
    cmp("staged fb", 16'h0008, 16'(feedback_ratio));
    dev_wr(`RA_SOFT_RESET, `COMMIT_KEY, 1'b1);
    cmp("commit pulses", 16'h0001, 16'(pulses));
    cmp("pump code", 16'h0003, 16'(pump_current_code));
    cmp("pump ua", 16'h0008, 16'(pump_current_ua));
    cmp("vco code", 16'h0003, 16'(vco_post_divide_code));
    cmp("vco ratio", 16'h0010, 16'(vco_divide_ratio));
    cmp("fb ratio", 16'h0F08, 16'(feedback_ratio));
    cmp("schmitt bypass", 16'h0000, 16'(schmitt_bypass));
  endtask

  task automatic t_bad_addr;
    link_op({~asel, `RA_INPUT_CONTROL}, 8'h00, 3'b101, 1'b1, rd);
    cmp("control kept", 16'h0078, 16'(ctl_vec));
  endtask

  task automatic t_lock_slow;
    asel <= 1'b0;
    repeat (6) @(posedge ref_clk);
    link_op({1'b0, `RA_LOCK_STATUS}, 8'h00, 3'b110, 1'b0, rd);
    cmp("lock status", 16'h0001, 16'({rd[7:2], rd[1]}));
    dev_wr(`RA_OUTPUT_ENABLES, 8'h02, 1'b0);
    cmp("video enable", 16'h0001, 16'(video_out_enable));
  endtask

  task automatic finish_test;
    $display("checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_input();
    t_staged();
    t_bad_addr();
    t_lock_slow();
    finish_test();
  end

  // Transfers should end near 856 us; this leaves margin
  initial begin
    #1000000;
    num_errors++;
    $display("unexpected watchdog: expected done, seen hang");
    finish_test();
  end
endmodule
